// File: logic/ldd_diag.sv
// Diagnostics, measurement storage and status of the dual LED driver
`timescale 1ns/1ps
`default_nettype none
`include "ldd_cfg.svh"

module ldd_diag #(
    parameter int OPEN_CYCLES =
        (`LDD_OPEN_TIME_US * 1000) / `LDD_CLK_PERIOD_NS,
    parameter logic [7:0] TSD_LEVEL = `LDD_TSD_LEVEL_RESET
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [1:0]  dimCtrlInput,
    input  wire logic        adcValid,
    input  wire logic [1:0]  adcSource,
    input  wire logic [7:0]  adcData,
    input  wire logic        adcSeqDone,
    input  wire logic [1:0]  shortComp,
    input  wire logic [1:0]  overcurrentDet,
    input  wire logic        serialErr,
    input  wire logic [1:0]  buckOnPhase,
    input  wire logic [1:0]  switchPeriodEnd,
    input  wire logic [1:0]  inductorZero,
    input  wire logic [1:0]  minOnDet,
    input  wire logic        regRead,
    input  wire logic        regWrite,
    input  wire logic [6:0]  regAddr,
    input  wire logic [15:0] regWdata,
    output var  logic [15:0] regRdata,
    output wire logic [1:0]  buckEnable,
    output var  logic [1:0]  measRequest,
    output wire logic [1:0]  offTimeEnd,
    output wire logic [3:0]  stringVoltRangeSel,
    output wire logic [15:0] stringVoltFullScale
);
    localparam int OW = $clog2(OPEN_CYCLES + 1);

    // ====
    // Control registers
    logic [3:0] rangeSel;
    logic [7:0] warnThreshold;
    logic [1:0] chanEnBit;
    logic [1:0] autoRecover;
    logic [8:0] forcedInterval;

    wire wrRange  = regWrite && (regAddr == `LDD_ADDR_RANGE);
    wire wrThr    = regWrite && (regAddr == `LDD_ADDR_WARN_THR);
    wire wrCtrl   = regWrite && (regAddr == `LDD_ADDR_CHAN_CTRL);
    wire wrForced = regWrite && (regAddr == `LDD_ADDR_FORCED);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rangeSel       <= 4'h0;
            warnThreshold  <= `LDD_WARN_THR_RESET; // RULE6
            chanEnBit      <= 2'h0;
            autoRecover    <= 2'h0;
            forcedInterval <= 9'h000;
        end
        else
        begin
            if (wrRange)
                rangeSel <= regWdata[3:0]; // RULE1
            if (wrThr)
                warnThreshold <= regWdata[7:0];
            if (wrCtrl)
            begin
                chanEnBit   <= regWdata[`LDD_CC_ENABLE +: 2];
                autoRecover <= regWdata[`LDD_CC_AUTOREC +: 2];
            end
            if (wrForced)
                forcedInterval <= regWdata[8:0];
        end
    end

    assign stringVoltRangeSel = rangeSel;

    // ====
    // Temperature, warning and shutdown
    ldd_pkg::ldd_result_t tempResult;
    logic                 tsdActive;

    wire tempHit  = adcValid && (adcSource == ldd_pkg::SRC_TEMP);
    wire tempWarn = (tempResult[7:0] >= warnThreshold); // RULE5
    wire tempHot  = (tempResult[7:0] >= TSD_LEVEL);
    wire tsdStart = tempHot && !tsdActive;
    wire tsdEnd   = tsdActive && !tempWarn; // RULE7

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tempResult <= 9'h100;
            tsdActive  <= 1'b0;
        end
        else
        begin
            if (tempHit)
                tempResult <= {~^adcData, adcData}; // RULE24
            if (tsdStart)
                tsdActive <= 1'b1;
            else if (tsdEnd)
                tsdActive <= 1'b0;
        end
    end

    // ====
    // Per-channel logic
    logic [1:0] dimLevel;
    logic [1:0] chanStatus;
    logic [1:0] openSet;
    logic [1:0] shortSet;
    logic [8:0] voltRes   [2];
    logic [8:0] voltOnRes [2];
    logic [7:0] tonDur    [2];

    genvar ch;
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
        localparam logic [1:0] MY_SRC =
            (ch == 0) ? ldd_pkg::SRC_VOLT1 : ldd_pkg::SRC_VOLT2;

        logic          dimPrev;
        logic          enPrev;
        logic          run;
        logic          shortMask;
        logic [8:0]    seqCount;
        logic [OW-1:0] openCount;
        logic [8:0]    volt;
        logic [8:0]    voltOn;
        logic [7:0]    scale;

        wire dimFall    = dimPrev & ~dimLevel[ch];
        wire intervalNz = (forcedInterval != 9'h000);
        wire forceHit   = adcSeqDone && intervalNz &&
                          (seqCount >= forcedInterval - 9'h001);
        wire reqNow     = dimFall | forceHit;
        wire voltHit    = adcValid && (adcSource == MY_SRC);
        wire enRise     = chanEnBit[ch] & ~enPrev;
        wire onActive   = buckOnPhase[ch] & buckEnable[ch];
        wire openDone   = (openCount == OW'(OPEN_CYCLES - 1));

        ldd_debounce u_debounce (
            .clock (clock),
            .rst_n (rst_n),
            .pinIn (dimCtrlInput[ch]),
            .level (dimLevel[ch])
        );

        ldd_ontime u_ontime (
            .clock    (clock),
            .rst_n    (rst_n),
            .onPhase  (onActive),
            .duration (tonDur[ch])
        );

        // A falling edge restarts the cadence, so only steady inputs force
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                dimPrev         <= 1'b0;
                seqCount        <= 9'h000;
                measRequest[ch] <= 1'b0;
            end
            else
            begin
                dimPrev         <= dimLevel[ch];
                measRequest[ch] <= reqNow; // RULE4 RULE23
                if (reqNow)
                    seqCount <= 9'h000;
                else if (adcSeqDone && seqCount != 9'h1FF)
                    seqCount <= seqCount + 9'h001;
            end
        end

        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                volt   <= 9'h100;
                voltOn <= 9'h100;
            end
            else if (voltHit)
            begin
                volt <= {~^adcData, adcData}; // RULE3 RULE24
                if (dimLevel[ch])
                    voltOn <= {~^adcData, adcData}; // RULE22
            end
        end

        // Lost on overcurrent, or on shutdown without auto recovery; regained on enable rising edge
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                enPrev <= 1'b0;
                run    <= 1'b1;
            end
            else
            begin
                enPrev <= chanEnBit[ch];
                if (overcurrentDet[ch])
                    run <= 1'b0; // RULE13
                else if (tsdStart && !autoRecover[ch])
                    run <= 1'b0; // RULE8
                else if (enRise)
                    run <= 1'b1; // RULE8
            end
        end

        // Short masked until the first period ends
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                shortMask <= 1'b1;
                openCount <= '0;
            end
            else
            begin
                if (!buckEnable[ch])
                    shortMask <= 1'b1;
                else if (switchPeriodEnd[ch])
                    shortMask <= 1'b0; // RULE11
                if (!onActive)
                    openCount <= '0;
                else if (!openDone)
                    openCount <= openCount + OW'(1); // RULE10
            end
        end

        always_comb
        begin
            unique case (rangeSel[2*ch +: 2])
                2'h0:    scale = `LDD_SCALE_RANGE0; // RULE2
                2'h1:    scale = `LDD_SCALE_RANGE1;
                2'h2:    scale = `LDD_SCALE_RANGE2;
                2'h3:    scale = `LDD_SCALE_RANGE3;
            endcase
        end

        // Besides a cleared enable bit, only shutdown and overcurrent stop a channel
        assign buckEnable[ch] = chanEnBit[ch] & run & ~tsdActive; // RULE7 RULE20
        assign chanStatus[ch] = buckEnable[ch] & dimLevel[ch]; // RULE14
        assign openSet[ch]    = onActive & openDone; // RULE10
        assign shortSet[ch]   = buckEnable[ch] & ~shortMask & shortComp[ch]; // RULE11
        assign offTimeEnd[ch] = shortComp[ch] & inductorZero[ch]; // RULE12
        assign voltRes[ch]    = volt;
        assign voltOnRes[ch]  = voltOn;
        assign stringVoltFullScale[8*ch +: 8] = scale;
    end

    // ====
    // Latched flags, cleared by reading their register
    logic [7:0] chanFlags;
    logic [3:0] devFlags;

    wire rdChan = regRead && (regAddr == `LDD_ADDR_CHAN_FLAGS);
    wire rdDev  = regRead && (regAddr == `LDD_ADDR_DEV_FLAGS);

    wire [7:0] chanSet = {minOnDet, overcurrentDet, shortSet, openSet};
    wire [3:0] devSet  = {1'b0, serialErr, tsdStart, tempWarn};

    // Set after clear, so a coinciding event survives
    wire [7:0] next_chanFlags =
        (chanFlags & ~{8{rdChan}}) | chanSet; // RULE16 RULE19 RULE21
    wire [3:0] next_devFlags =
        (devFlags & ~{4{rdDev}}) | devSet; // RULE9 RULE19 RULE21

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chanFlags <= 8'h00;
            devFlags  <= 4'h8; // RULE18
        end
        else
        begin
            chanFlags <= next_chanFlags;
            devFlags  <= next_devFlags;
        end
    end

    // ====
    // Read path
    logic [15:0] readMux;

    always_comb
    begin
        unique case (regAddr)
            `LDD_ADDR_CHAN_FLAGS: readMux = {8'h00, chanFlags};
            `LDD_ADDR_DEV_FLAGS:  readMux = {8'h00, chanStatus,
                                             dimLevel, devFlags}; // RULE15
            `LDD_ADDR_VOLT1:      readMux = {7'h00, voltRes[0]};
            `LDD_ADDR_VOLT2:      readMux = {7'h00, voltRes[1]};
            `LDD_ADDR_VOLT_ON1:   readMux = {7'h00, voltOnRes[0]};
            `LDD_ADDR_VOLT_ON2:   readMux = {7'h00, voltOnRes[1]};
            `LDD_ADDR_TEMP:       readMux = {7'h00, tempResult};
            `LDD_ADDR_TON1:       readMux = {8'h00, tonDur[0]};
            `LDD_ADDR_TON2:       readMux = {8'h00, tonDur[1]};
            `LDD_ADDR_RANGE:      readMux = {12'h000, rangeSel};
            `LDD_ADDR_WARN_THR:   readMux = {8'h00, warnThreshold};
            `LDD_ADDR_CHAN_CTRL:  readMux = {12'h000, autoRecover,
                                             chanEnBit};
            `LDD_ADDR_FORCED:     readMux = {7'h00, forcedInterval};
            default:              readMux = 16'h0000;
        endcase
    end

    // Taken on the clearing edge, so flags are seen before the clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= 16'h0000;
        else if (regRead)
            regRdata <= readMux;
    end
endmodule
`default_nettype wire

// File: logic/ldd_cfg.svh
// Constants of the LED driver diagnostics block
// Operation
// RULE1 - Two-bit string voltage range select per channel.
// RULE2 - Range codes 0..3 scale 70, 50, 40, 30 V over 255.
// RULE3 - String voltage results, general and on-state, kept with parity.
// RULE4 - Steady dimming input still gets periodic forced requests.
// RULE5 - Warning flag latches when temperature reaches threshold.
// RULE6 - Warning threshold resets to code 179.
// RULE7 - Shutdown stops both channels, latches; ends below warning level.
// RULE8 - After shutdown, auto restart or restart on enable rising edge.
// RULE9 - Serial error latches its flag.
// RULE10 - Open counter overflow, about 50 us on, sets open flag.
// RULE11 - Low string voltage sets short flag; enabled only, first period masked.
// RULE12 - Low string voltage ends off-time at inductor current zero.
// RULE13 - Overcurrent latches channel flag and stops that channel.
// RULE14 - Status bit is one exactly while channel regulates.
// RULE15 - Dimming inputs debounced 200 ns; levels readable.
// RULE16 - Minimum on-time flag per channel, cleared on read.
// RULE17 - Last on-time in 200 ns steps; short reads zero; held when stopped.
// RULE18 - Power-on flag set only by power-on reset.
// RULE19 - Every latched flag clears when its register is read.
// RULE20 - Only overcurrent and shutdown disable outputs.
// RULE21 - Flag event coinciding with clear-on-read leaves flag set.
// RULE22 - Dimming high updates both results, else general only.
// RULE23 - Nonzero interval repeats request every interval sequences.
// RULE24 - Odd parity of each result in bit 8.
`ifndef LDD_CFG_SVH
`define LDD_CFG_SVH

// ====
// Timing
`define LDD_CLK_PERIOD_NS       10
`define LDD_DEBOUNCE_NS         200
`define LDD_ONTIME_STEP_NS      200
`define LDD_OPEN_TIME_US        50

// ====
// Register offsets
`define LDD_ADDR_CHAN_FLAGS     7'h15
`define LDD_ADDR_DEV_FLAGS      7'h16
`define LDD_ADDR_VOLT1          7'h20
`define LDD_ADDR_VOLT2          7'h21
`define LDD_ADDR_VOLT_ON1       7'h22
`define LDD_ADDR_VOLT_ON2       7'h23
`define LDD_ADDR_TEMP           7'h24
`define LDD_ADDR_TON1           7'h25
`define LDD_ADDR_TON2           7'h26
`define LDD_ADDR_RANGE          7'h30
`define LDD_ADDR_WARN_THR       7'h31
`define LDD_ADDR_CHAN_CTRL      7'h32
`define LDD_ADDR_FORCED         7'h33

// ====
// Field positions
`define LDD_CF_OPEN             0
`define LDD_CF_SHORT            2
`define LDD_CF_OVERCUR          4
`define LDD_CF_MINTON           6
`define LDD_DF_WARN             0
`define LDD_DF_SHUTDOWN         1
`define LDD_DF_SERIAL           2
`define LDD_DF_POWERON          3
`define LDD_DF_DIMLEVEL         4
`define LDD_DF_STATUS           6
`define LDD_CC_ENABLE           0
`define LDD_CC_AUTOREC          2
`define LDD_PARITY_BIT          8

// ====
// Reset values and scale factors
`define LDD_WARN_THR_RESET      8'hB3
`define LDD_TSD_LEVEL_RESET     8'hC8
`define LDD_SCALE_RANGE0        8'h46
`define LDD_SCALE_RANGE1        8'h32
`define LDD_SCALE_RANGE2        8'h28
`define LDD_SCALE_RANGE3        8'h1E

`endif

// File: logic/ldd_pkg.sv
// Types shared by the LED driver diagnostics files
package ldd_pkg;
    typedef enum logic [1:0] {
        SRC_TEMP  = 2'b00,
        SRC_VOLT1 = 2'b01,
        SRC_VOLT2 = 2'b10,
        SRC_OTHER = 2'b11
    } ldd_adc_src_t;

    typedef logic [8:0] ldd_result_t;
endpackage

// File: logic/ldd_debounce.sv
// Pin synchroniser and debounce filter for one dimming input
`timescale 1ns/1ps
`default_nettype none
`include "ldd_cfg.svh"

module ldd_debounce #(
    parameter int FILTER_CYCLES =
        (`LDD_DEBOUNCE_NS + `LDD_CLK_PERIOD_NS - 1) / `LDD_CLK_PERIOD_NS
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pinIn,
    output var  logic level
);
    localparam int CW = $clog2(FILTER_CYCLES + 1);

    logic          syncA;
    logic          syncB;
    logic          syncC;
    logic [CW-1:0] stableCount;

    wire agree   = (syncB == syncC);
    wire differs = (syncC != level);
    wire done    = (stableCount == CW'(FILTER_CYCLES - 1));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA <= 1'b0;
            syncB <= 1'b0;
            syncC <= 1'b0;
        end
        else
        begin
            syncA <= pinIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // Level moves only after a full filter time
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stableCount <= '0;
            level       <= 1'b0;
        end
        else if (!agree || !differs)
            stableCount <= '0;
        else if (done)
        begin
            stableCount <= '0;
            level       <= syncC; // RULE15
        end
        else
            stableCount <= stableCount + CW'(1);
    end
endmodule
`default_nettype wire

// File: logic/ldd_ontime.sv
// On-time measurement of one buck channel in fixed steps
`timescale 1ns/1ps
`default_nettype none
`include "ldd_cfg.svh"

module ldd_ontime #(
    parameter int STEP_CYCLES =
        `LDD_ONTIME_STEP_NS / `LDD_CLK_PERIOD_NS
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       onPhase,
    output var  logic [7:0] duration
);
    localparam int PW = $clog2(STEP_CYCLES + 1);

    logic          onPrev;
    logic [PW-1:0] prescale;
    logic [7:0]    steps;

    wire stepDone = (prescale == PW'(STEP_CYCLES - 1));
    wire onEnd    = onPrev & ~onPhase;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            onPrev   <= 1'b0;
            prescale <= '0;
            steps    <= 8'h00;
            duration <= 8'h00;
        end
        else
        begin
            onPrev <= onPhase;
            if (onEnd)
            begin
                duration <= steps; // RULE17
                steps    <= 8'h00;
                prescale <= '0;
            end
            else if (onPhase)
            begin
                prescale <= stepDone ? '0 : prescale + PW'(1);
                // Saturate rather than wrap on very long on-times
                if (stepDone && steps != 8'hFF)
                    steps <= steps + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/ldd_diag_fix_note.sv
// Spare design unit; holds no logic

// File: tb/ldd_diag_sva.sv
// Assertion checker for the LED driver diagnostics block
`timescale 1ns/1ps
`default_nettype none

module ldd_diag_sva #(
    parameter logic [7:0] TSD_LEVEL = 8'hC8
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        adcValid,
    input wire logic [1:0]  adcSource,
    input wire logic [7:0]  adcData,
    input wire logic        adcSeqDone,
    input wire logic [1:0]  shortComp,
    input wire logic [1:0]  overcurrentDet,
    input wire logic        serialErr,
    input wire logic [1:0]  inductorZero,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [6:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic [1:0]  buckEnable,
    input wire logic [1:0]  measRequest,
    input wire logic [1:0]  offTimeEnd,
    input wire logic [3:0]  stringVoltRangeSel,
    input wire logic [15:0] stringVoltFullScale
);
    logic [7:0] warnThr;
    logic [8:0] forcedIv;

    // ====
    // Shadow copies of the warning threshold and forced interval settings
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            warnThr  <= 8'hB3;
            forcedIv <= 9'h000;
        end
        else if (regWrite && regAddr == 7'h31)
            warnThr <= regWdata[7:0];
        else if (regWrite && regAddr == 7'h33)
            forcedIv <= regWdata[8:0];
    end

    function automatic logic [7:0] scaleOf(input logic [1:0] code);
        return code == 2'h0 ? 8'h46 : code == 2'h1 ? 8'h32 :
               code == 2'h2 ? 8'h28 : 8'h1E;
    endfunction

    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ====
    // Properties
    a_range_follows: assert property (
        regWrite && regAddr == 7'h30 |=>
        stringVoltRangeSel == $past(regWdata[3:0]))
        else $error("range select did not take the written code");
    a_scale_table: assert property (
        stringVoltFullScale == {scaleOf(stringVoltRangeSel[3:2]),
                                scaleOf(stringVoltRangeSel[1:0])})
        else $error("full scale does not match range code");
    a_warn_flag_set: assert property (
        adcValid && adcSource == ldd_pkg::SRC_TEMP && adcData >= warnThr
        ##3 regRead && regAddr == 7'h16 |=> regRdata[0])
        else $error("warning flag missing after hot reading");
    a_shutdown_off: assert property (
        adcValid && adcSource == ldd_pkg::SRC_TEMP && adcData >= TSD_LEVEL
        |-> ##3 buckEnable == 2'b00)
        else $error("outputs still on after shutdown reading");
    a_serial_kept: assert property (
        serialErr && regRead && regAddr == 7'h16
        ##2 regRead && regAddr == 7'h16 |=> regRdata[2])
        else $error("serial error lost against clearing read");
    a_overcur_off: assert property (
        overcurrentDet[1] |=> !buckEnable[1] [*4])
        else $error("channel two not stopped by overcurrent");
    a_offtime_cut: assert property (
        offTimeEnd == (shortComp & inductorZero))
        else $error("off time end does not follow low string");
    a_forced_meas: assert property (
        adcSeqDone && forcedIv == 9'h001 |=> measRequest == 2'b11)
        else $error("forced request missing at interval one");
    a_status_live: assert property (
        regRead && regAddr == 7'h16 |=>
        (regRdata[7:6] & ~$past(buckEnable)) == 2'b00)
        else $error("status shows a channel that is not enabled");
    a_parity_odd: assert property (
        regRead && regAddr >= 7'h20 && regAddr <= 7'h24 |=> ^regRdata[8:0])
        else $error("result read back with even parity");
endmodule

bind ldd_diag ldd_diag_sva #(.TSD_LEVEL(TSD_LEVEL)) ldd_diag_sva_inst (
    .clock(clock), .rst_n(rst_n), .adcValid(adcValid),
    .adcSource(adcSource), .adcData(adcData), .adcSeqDone(adcSeqDone),
    .shortComp(shortComp), .overcurrentDet(overcurrentDet),
    .serialErr(serialErr), .inductorZero(inductorZero),
    .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .buckEnable(buckEnable),
    .measRequest(measRequest), .offTimeEnd(offTimeEnd),
    .stringVoltRangeSel(stringVoltRangeSel),
    .stringVoltFullScale(stringVoltFullScale)
);
`default_nettype wire

// File: tb/ldd_mcu_model.sv
// Controller model driving the register access port
`timescale 1ns/1ps
`default_nettype none

module ldd_mcu_model (
    input  wire logic        clock,
    input  wire logic [15:0] regRdata,
    output var  logic        regRead,
    output var  logic        regWrite,
    output var  logic [6:0]  regAddr,
    output var  logic [15:0] regWdata
);
    initial
    begin
        regRead  = 1'b0;
        regWrite = 1'b0;
        regAddr  = 7'h7F;
        regWdata = 16'h0000;
    end

    // Idle cycle at the end keeps two strobes apart
    task automatic access(input logic wr, input logic [6:0] addr,
                          input logic [15:0] data, output logic [15:0] rdat);
        regRead  = !wr;
        regWrite = wr;
        regAddr  = addr;
        regWdata = data;
        @(posedge clock);
        @(negedge clock);
        rdat     = regRdata;
        regRead  = 1'b0;
        regWrite = 1'b0;
        // Released lines show the inverse, not a stale copy
        regAddr  = ~addr;
        regWdata = ~data;
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

// File: tb/ldd_diag_bench.sv
// Self-checking bench for the LED driver diagnostics block
`timescale 1ns/1ps
`default_nettype none

`define LDD_CHK(got, exp) \
    begin \
        nCompared++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("Error at %0t: got %0h, expected %0h", \
                     $time, got, exp); \
        end \
    end

module ldd_diag_bench;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  dimCtrlInput = 2'b00;
    logic        adcValid = 1'b0;
    logic [1:0]  adcSource = 2'b11;
    logic [7:0]  adcData = 8'h00;
    logic        adcSeqDone = 1'b0;
    logic [1:0]  shortComp = 2'b00;
    logic [1:0]  overcurrentDet = 2'b00;
    logic        serialErr = 1'b0;
    logic [1:0]  buckOnPhase = 2'b00;
    logic [1:0]  switchPeriodEnd = 2'b00;
    logic [1:0]  inductorZero = 2'b00;
    logic [1:0]  minOnDet = 2'b00;
    wire  logic        regRead, regWrite;
    wire  logic [6:0]  regAddr;
    wire  logic [15:0] regWdata, regRdata, stringVoltFullScale;
    wire  logic [1:0]  buckEnable, measRequest, offTimeEnd;
    wire  logic [3:0]  stringVoltRangeSel;
    int          fails = 0;
    int          nCompared = 0;
    logic [7:0]  scale [4] = '{8'h46, 8'h32, 8'h28, 8'h1E};

    always #5 clock = ~clock;

    ldd_diag #(.OPEN_CYCLES(16)) ldd_diag_inst (
        .clock(clock), .rst_n(rst_n), .dimCtrlInput(dimCtrlInput),
        .adcValid(adcValid), .adcSource(adcSource), .adcData(adcData),
        .adcSeqDone(adcSeqDone), .shortComp(shortComp),
        .overcurrentDet(overcurrentDet), .serialErr(serialErr),
        .buckOnPhase(buckOnPhase), .switchPeriodEnd(switchPeriodEnd),
        .inductorZero(inductorZero), .minOnDet(minOnDet),
        .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .buckEnable(buckEnable),
        .measRequest(measRequest), .offTimeEnd(offTimeEnd),
        .stringVoltRangeSel(stringVoltRangeSel),
        .stringVoltFullScale(stringVoltFullScale));
    ldd_mcu_model ldd_mcu_model_inst (
        .clock(clock), .regRdata(regRdata), .regRead(regRead),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata));

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] unused;
        ldd_mcu_model_inst.access(1'b1, a, d, unused);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] got;
        ldd_mcu_model_inst.access(1'b0, a, 16'h0000, got);
        `LDD_CHK(got, exp)
    endtask
    task automatic adc(input logic [1:0] src, input logic [7:0] d);
        adcValid  = 1'b1;
        adcSource = src;
        adcData   = d;
        @(negedge clock);
        adcValid  = 1'b0;
        adcData   = ~d;
    endtask
    task automatic waitCycles(input int n);
        repeat (n) @(negedge clock);
    endtask
    function automatic logic [15:0] res(input logic [7:0] v);
        return {7'h00, ~^v, v};
    endfunction
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        waitCycles(4);
        rst_n = 1'b1;
        waitCycles(1);
        rd(7'h16, 16'h0008);
        rd(7'h16, 16'h0000);
        rd(7'h31, 16'h00B3);
        rd(7'h20, 16'h0100);
        rd(7'h7F, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            wr(7'h30, {12'h000, c[1:0], c[1:0]});
            `LDD_CHK(stringVoltFullScale, {2{scale[c]}})
        end
        $display("Test reset and ranges done");
        // Dim high, then falling edge
        dimCtrlInput = 2'b01;
        waitCycles(30);
        adc(2'b01, 8'h5A);
        rd(7'h20, res(8'h5A));
        rd(7'h22, res(8'h5A));
        dimCtrlInput = 2'b00;
        for (int k = 0; k < 60 && measRequest !== 2'b01; k++)
            @(negedge clock);
        `LDD_CHK(measRequest, 2'b01)
        adc(2'b01, 8'h07);
        rd(7'h20, res(8'h07));
        rd(7'h22, res(8'h5A));
        adc(2'b10, 8'hFF);
        rd(7'h21, res(8'hFF));
        rd(7'h23, 16'h0100);
        // Steady dimming: forced cadence only
        for (int iv = 1; iv <= 2; iv++)
        begin
            wr(7'h33, 16'(iv));
            for (int k = 1; k <= iv; k++)
            begin
                adcSeqDone = 1'b1;
                @(negedge clock);
                adcSeqDone = 1'b0;
                `LDD_CHK(measRequest, (k == iv) ? 2'b11 : 2'b00)
                waitCycles(1);
            end
        end
        wr(7'h33, 16'h0000);
        $display("Test measurements done");
        dimCtrlInput = 2'b01;
        wr(7'h32, 16'h0003);
        `LDD_CHK(buckEnable, 2'b11)
        switchPeriodEnd = 2'b11;
        waitCycles(1);
        switchPeriodEnd = 2'b00;
        shortComp = 2'b01;
        inductorZero = 2'b01;
        buckOnPhase = 2'b01;
        minOnDet = 2'b10;
        overcurrentDet = 2'b10;
        waitCycles(1);
        minOnDet = 2'b00;
        overcurrentDet = 2'b00;
        waitCycles(44);
        `LDD_CHK(offTimeEnd, 2'b01)
        buckOnPhase = 2'b00;
        shortComp = 2'b00;
        waitCycles(2);
        `LDD_CHK(buckEnable, 2'b01)
        rd(7'h15, 16'h00A5);
        rd(7'h15, 16'h0000);
        rd(7'h25, 16'h0002);
        rd(7'h16, 16'h0050);
        $display("Test channel faults done");
        wr(7'h32, 16'h0001);
        adc(2'b00, 8'hC8);
        waitCycles(2);
        rd(7'h16, 16'h0013);
        adc(2'b00, 8'h10);
        waitCycles(2);
        `LDD_CHK(buckEnable, 2'b00)
        wr(7'h32, 16'h0000);
        wr(7'h32, 16'h0005);
        `LDD_CHK(buckEnable, 2'b01)
        adc(2'b00, 8'hC8);
        adc(2'b00, 8'hB4);
        waitCycles(2);
        `LDD_CHK(buckEnable, 2'b00)
        adc(2'b00, 8'h10);
        waitCycles(2);
        `LDD_CHK(buckEnable, 2'b01)
        // Error on the clearing edge
        serialErr = 1'b1;
        fork
            rd(7'h16, 16'h0053);
            begin
                @(negedge clock);
                serialErr = 1'b0;
            end
        join
        rd(7'h16, 16'h0054);
        rd(7'h16, 16'h0050);
        $display("Test thermal and serial done");
        end_of_test();
    end
endmodule
`default_nettype wire
